// ### rtl/slm_defines.svh
`ifndef SLM_DEFINES_SVH
`define SLM_DEFINES_SVH

// ----------------------------------------
// register indices, byte address = index * 4
// ----------------------------------------
`define SLM_IDX_SYNC_SEL  11'h47B
`define SLM_IDX_ERR_LIM   11'h47C
`define SLM_IDX_LANE_ON   11'h47D
`define SLM_IDX_RAMP_CHK  11'h47E
`define SLM_IDX_DIG_TEST  11'h520
`define SLM_IDX_I_LOW     11'h521
`define SLM_IDX_I_HIGH    11'h522
`define SLM_IDX_Q_LOW     11'h523
`define SLM_IDX_Q_HIGH    11'h524
`define SLM_IDX_IRQ_STAT  11'h480
`define SLM_IDX_IRQ_MASK  11'h481

// ----------------------------------------
// field positions
// ----------------------------------------
`define SLM_B_DISP     7
`define SLM_B_NIT      6
`define SLM_B_UCC      5
`define SLM_B_MM_ST    4
`define SLM_B_MM_EN    3
`define SLM_B_RAMP     3
`define SLM_B_RAMP_CHK 0
`define SLM_B_DC_TEST  1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLM_RST_ERR_LIM  8'hFF
`define SLM_RST_LANE_ON  8'h0F
`define SLM_RST_DIG_TEST 8'h1C
`define SLM_RST_MM_EN    1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define SLM_CLK_MHZ    50
`define SLM_RESYNC_NS  80
`define SLM_RESYNC_CYC ((`SLM_RESYNC_NS * `SLM_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/slm_pkg.sv
package slm_pkg;

  typedef enum logic [1:0] {
    SLM_IDLE  = 2'h0,
    SLM_HOLD  = 2'h1,
    SLM_CLEAR = 2'h3
  } slm_sync_st_t;

  typedef struct packed {
    logic [2:0][7:0] cnt;
    logic            ramp_act;
    logic [1:0]      ramp_pos;
    logic            ramp_fail;
  } slm_lane_t;

  typedef struct packed {
    logic [2:0]   sync_sel;
    logic         param_mismatch_status;
    logic         param_mismatch_irq_on;
    logic [7:0]   limit;
    logic [7:0]   lane_on;
    logic         ramp_chk;
    logic [7:0]   dig_test;
    logic [15:0]  i_const;
    logic [15:0]  q_const;
    logic [7:0]   irq_stat;
    logic [7:0]   irq_mask;
    logic         mm_prev;
    slm_sync_st_t st;
    logic [7:0]   rs_cnt;
    logic         ack;
    logic [31:0]  rdata;
    logic         irq_n;
    logic         rs_n;
    logic         fail;
    logic [15:0]  i_out;
    logic [15:0]  q_out;
  } slm_top_t;

endpackage : slm_pkg

// ### rtl/slm_lane.sv
`timescale 1ns/1ns
`include "slm_defines.svh"
module slm_lane
  import slm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       lane_on,
  input  wire logic       count_clr,
  input  wire logic [7:0] limit,
  input  wire logic       ramp_chk,
  // error events: 0 disparity, 1 invalid code, 2 unexpected control
  input  wire logic [2:0] err,
  // alignment sequence bytes
  input  wire logic       ilas_begin,
  input  wire logic       ilas_valid,
  input  wire logic [7:0] ilas_byte,
  // results
  output logic      [2:0] hit,
  output logic            ramp_fail
);

  slm_lane_t r_reg;
  slm_lane_t r_next;

  always_comb begin
    r_next = r_reg;
    for (int k = 0; k < 3; k++) begin
      if (!lane_on || count_clr) begin
        r_next.cnt[k] = 8'h00;
      end else if (err[k] && r_reg.cnt[k] != 8'hFF) begin
        r_next.cnt[k] = r_reg.cnt[k] + 8'h01;
      end
    end
    if (!lane_on) begin
      r_next.ramp_act  = 1'b0;
      r_next.ramp_pos  = 2'h0;
      r_next.ramp_fail = 1'b0;
    end else if (ilas_valid && ilas_begin) begin
      r_next.ramp_act  = 1'b1;
      r_next.ramp_pos  = 2'h1;
      r_next.ramp_fail = ramp_chk && ilas_byte != 8'h00;
    end else if (ilas_valid && r_reg.ramp_act) begin
      if (ramp_chk && ilas_byte != {6'h00, r_reg.ramp_pos}) begin
        r_next.ramp_fail = 1'b1;
      end
      r_next.ramp_pos = r_reg.ramp_pos + 2'h1;
      if (r_reg.ramp_pos == 2'h2) begin
        r_next.ramp_act = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      hit[k] = lane_on && r_reg.cnt[k] >= limit;
    end
    ramp_fail = r_reg.ramp_fail;
  end

  property p_cnt_inc;
    @(posedge clk) disable iff (rst)
    lane_on && !count_clr && err[0] && r_reg.cnt[0] != 8'hFF |=> r_reg.cnt[0] == $past(r_reg.cnt[0]) + 8'h01;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("disparity count did not advance");

  property p_ramp_off;
    @(posedge clk) disable iff (rst)
    lane_on && !ramp_chk && ilas_valid && ilas_begin |=> !ramp_fail;
  endproperty
  a_ramp_off: assert property (p_ramp_off) else $error("ramp failure with check off");

  sequence s_bad_start;
    lane_on && ramp_chk && ilas_valid && ilas_begin && ilas_byte != 8'h00;
  endsequence

  property p_ramp_bad;
    @(posedge clk) disable iff (rst)
    s_bad_start |=> ramp_fail;
  endproperty
  a_ramp_bad: assert property (p_ramp_bad) else $error("bad ramp start not flagged");

endmodule : slm_lane

// ### rtl/slm_top.sv
`timescale 1ns/1ns
`include "slm_defines.svh"
// ----------------------------------------
// ----------------------------------------
module slm_top
  import slm_pkg::*;
#(
  parameter int NUM_LANES = 8
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // wishbone slave
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  input  wire logic                   WB_WE_I,
  input  wire logic [12:0]            WB_ADR_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  output logic                        WB_ACK_O,
  // per-lane error events
  input  wire logic [NUM_LANES-1:0]   DISP_ERR,
  input  wire logic [NUM_LANES-1:0]   NIT_ERR,
  input  wire logic [NUM_LANES-1:0]   UCC_ERR,
  // alignment sequence
  input  wire logic [NUM_LANES-1:0]   ILAS_BEGIN,
  input  wire logic [NUM_LANES-1:0]   ILAS_VALID,
  input  wire logic [8*NUM_LANES-1:0] ILAS_DATA,
  // link parameters
  input  wire logic [111:0]           RX_LANE0_PARAMS,
  input  wire logic [111:0]           LOCAL_PARAMS,
  // samples
  input  wire logic [15:0]            I_IN,
  input  wire logic [15:0]            Q_IN,
  output logic      [15:0]            I_OUT,
  output logic      [15:0]            Q_OUT,
  // link and status
  output logic                        RESYNC_REQUEST_OUT_N,
  output logic                        IRQ_N,
  output logic      [7:0]             LANE_ON_BITS,
  output logic                        ILAS_RAMP_FAIL
);

  slm_top_t r_reg;
  slm_top_t r_next;

  logic [NUM_LANES-1:0] disp_hit;
  logic [NUM_LANES-1:0] nit_hit;
  logic [NUM_LANES-1:0] ucc_hit;
  logic [NUM_LANES-1:0] lane_fail;
  logic                 any_disp;
  logic                 any_nit;
  logic                 any_ucc;
  logic                 any_fail;
  logic                 wr;
  logic [10:0]          idx;
  logic                 mm;
  logic                 mm_rise;
  logic                 trig;

  // ----------------------------------------
  // per-lane counters and ramp check
  // ----------------------------------------
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    logic [2:0] lane_hit;

    slm_lane u_lane (
      .clk        (CLK),
      .rst        (SYS_RST),
      .lane_on    (r_reg.lane_on[i]),
      .count_clr  (r_reg.st == SLM_CLEAR),
      .limit      (r_reg.limit),
      .ramp_chk   (r_reg.ramp_chk),
      .err        ({UCC_ERR[i], NIT_ERR[i], DISP_ERR[i]}),
      .ilas_begin (ILAS_BEGIN[i]),
      .ilas_valid (ILAS_VALID[i]),
      .ilas_byte  (ILAS_DATA[8*i +: 8]),
      .hit        (lane_hit),
      .ramp_fail  (lane_fail[i])
    );

    assign disp_hit[i] = lane_hit[0];
    assign nit_hit[i]  = lane_hit[1];
    assign ucc_hit[i]  = lane_hit[2];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_next   = r_reg;
    any_disp = |disp_hit;
    any_nit  = |nit_hit;
    any_ucc  = |ucc_hit;
    any_fail = |lane_fail;
    idx      = WB_ADR_I[12:2];
    wr       = WB_CYC_I && WB_STB_I && WB_WE_I && r_reg.ack && WB_SEL_I[0];
    mm       = RX_LANE0_PARAMS != LOCAL_PARAMS;
    mm_rise  = mm && !r_reg.mm_prev;
    trig     = (r_reg.sync_sel[2] && any_disp)
            || (r_reg.sync_sel[1] && any_nit)
            || (r_reg.sync_sel[0] && any_ucc);

    // bus answer, one cycle after the request
    r_next.ack   = WB_CYC_I && WB_STB_I && !r_reg.ack;
    r_next.rdata = 32'h0000_0000;
    if (idx == `SLM_IDX_SYNC_SEL) begin
      r_next.rdata[`SLM_B_DISP]   = r_reg.sync_sel[2];
      r_next.rdata[`SLM_B_NIT]    = r_reg.sync_sel[1];
      r_next.rdata[`SLM_B_UCC]    = r_reg.sync_sel[0];
      r_next.rdata[`SLM_B_MM_ST]  = r_reg.param_mismatch_status;
      r_next.rdata[`SLM_B_MM_EN]  = r_reg.param_mismatch_irq_on;
    end else if (idx == `SLM_IDX_ERR_LIM) begin
      r_next.rdata[7:0] = r_reg.limit;
    end else if (idx == `SLM_IDX_LANE_ON) begin
      r_next.rdata[7:0] = r_reg.lane_on;
    end else if (idx == `SLM_IDX_RAMP_CHK) begin
      r_next.rdata[`SLM_B_RAMP_CHK] = r_reg.ramp_chk;
    end else if (idx == `SLM_IDX_DIG_TEST) begin
      r_next.rdata[7:0] = r_reg.dig_test;
    end else if (idx == `SLM_IDX_I_LOW) begin
      r_next.rdata[7:0] = r_reg.i_const[7:0];
    end else if (idx == `SLM_IDX_I_HIGH) begin
      r_next.rdata[7:0] = r_reg.i_const[15:8];
    end else if (idx == `SLM_IDX_Q_LOW) begin
      r_next.rdata[7:0] = r_reg.q_const[7:0];
    end else if (idx == `SLM_IDX_Q_HIGH) begin
      r_next.rdata[7:0] = r_reg.q_const[15:8];
    end else if (idx == `SLM_IDX_IRQ_STAT) begin
      r_next.rdata[7:0] = r_reg.irq_stat;
    end else if (idx == `SLM_IDX_IRQ_MASK) begin
      r_next.rdata[7:0] = r_reg.irq_mask;
    end

    // register writes, taken on the acknowledged edge
    if (wr) begin
      if (idx == `SLM_IDX_SYNC_SEL) begin
        r_next.sync_sel = {WB_DAT_I[`SLM_B_DISP], WB_DAT_I[`SLM_B_NIT], WB_DAT_I[`SLM_B_UCC]};
        r_next.param_mismatch_irq_on = WB_DAT_I[`SLM_B_MM_EN];
        if (WB_DAT_I[`SLM_B_MM_ST]) begin
          r_next.param_mismatch_status = 1'b0;
        end
      end else if (idx == `SLM_IDX_ERR_LIM) begin
        r_next.limit = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_LANE_ON) begin
        r_next.lane_on = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_RAMP_CHK) begin
        r_next.ramp_chk = WB_DAT_I[`SLM_B_RAMP_CHK];
      end else if (idx == `SLM_IDX_DIG_TEST) begin
        r_next.dig_test = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_I_LOW) begin
        r_next.i_const[7:0] = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_I_HIGH) begin
        r_next.i_const[15:8] = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_Q_LOW) begin
        r_next.q_const[7:0] = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_Q_HIGH) begin
        r_next.q_const[15:8] = WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_IRQ_STAT) begin
        r_next.irq_stat = r_reg.irq_stat & ~WB_DAT_I[7:0];
      end else if (idx == `SLM_IDX_IRQ_MASK) begin
        r_next.irq_mask = WB_DAT_I[7:0];
      end
    end

    // events after writes, so a set beats a clear
    r_next.mm_prev = mm;
    if (!r_next.param_mismatch_irq_on) begin
      r_next.param_mismatch_status = 1'b0;
    end else if (mm_rise) begin
      r_next.param_mismatch_status = 1'b1;
    end
    if (any_disp) begin
      r_next.irq_stat[`SLM_B_DISP] = 1'b1;
    end
    if (any_nit) begin
      r_next.irq_stat[`SLM_B_NIT] = 1'b1;
    end
    if (any_ucc) begin
      r_next.irq_stat[`SLM_B_UCC] = 1'b1;
    end
    if (any_fail) begin
      r_next.irq_stat[`SLM_B_RAMP] = 1'b1;
    end

    // resync request sequencer
    case (r_reg.st)
      SLM_IDLE: begin
        if (trig) begin
          r_next.st     = SLM_HOLD;
          r_next.rs_cnt = 8'(`SLM_RESYNC_CYC - 1);
        end
      end
      SLM_HOLD: begin
        if (r_reg.rs_cnt == 8'h00) begin
          r_next.st = SLM_CLEAR;
        end else begin
          r_next.rs_cnt = r_reg.rs_cnt - 8'h01;
        end
      end
      SLM_CLEAR: begin
        r_next.st = SLM_IDLE;
      end
      default: begin
        r_next.st = SLM_IDLE;
      end
    endcase

    // registered outputs
    r_next.rs_n  = r_next.st != SLM_HOLD;
    r_next.irq_n = !((|(r_next.irq_stat & r_next.irq_mask)) || r_next.param_mismatch_status);
    r_next.fail  = any_fail;
    if (r_reg.dig_test[`SLM_B_DC_TEST]) begin
      r_next.i_out = r_reg.i_const;
      r_next.q_out = r_reg.q_const;
    end else begin
      r_next.i_out = I_IN;
      r_next.q_out = Q_IN;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_reg          <= '0;
      r_reg.limit    <= `SLM_RST_ERR_LIM;
      r_reg.lane_on  <= `SLM_RST_LANE_ON;
      r_reg.param_mismatch_irq_on <= `SLM_RST_MM_EN;
      r_reg.dig_test <= `SLM_RST_DIG_TEST;
      r_reg.st       <= SLM_IDLE;
      r_reg.irq_n    <= 1'b1;
      r_reg.rs_n     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign WB_DAT_O             = r_reg.rdata;
  assign WB_ACK_O             = r_reg.ack;
  assign I_OUT                = r_reg.i_out;
  assign Q_OUT                = r_reg.q_out;
  assign RESYNC_REQUEST_OUT_N = r_reg.rs_n;
  assign IRQ_N                = r_reg.irq_n;
  assign LANE_ON_BITS         = r_reg.lane_on;
  assign ILAS_RAMP_FAIL       = r_reg.fail;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_disp_sync;
    @(posedge CLK) disable iff (SYS_RST)
    r_reg.sync_sel[2] && any_disp && r_reg.st == SLM_IDLE |=> !RESYNC_REQUEST_OUT_N;
  endproperty
  a_disp_sync: assert property (p_disp_sync) else $error("disparity limit gave no resync");

  property p_nit_sync;
    @(posedge CLK) disable iff (SYS_RST)
    r_reg.sync_sel[1] && any_nit && r_reg.st == SLM_IDLE |=> !RESYNC_REQUEST_OUT_N;
  endproperty
  a_nit_sync: assert property (p_nit_sync) else $error("invalid code limit gave no resync");

  property p_ucc_sync;
    @(posedge CLK) disable iff (SYS_RST)
    r_reg.sync_sel[0] && any_ucc && r_reg.st == SLM_IDLE |=> !RESYNC_REQUEST_OUT_N;
  endproperty
  a_ucc_sync: assert property (p_ucc_sync) else $error("control char limit gave no resync");

  property p_sync_len;
    @(posedge CLK) disable iff (SYS_RST)
    $fell(RESYNC_REQUEST_OUT_N) |-> (!RESYNC_REQUEST_OUT_N) [*4] ##1 RESYNC_REQUEST_OUT_N;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("resync request length wrong");

  sequence s_mm_rise;
    r_reg.param_mismatch_irq_on && mm_rise && !(wr && idx == `SLM_IDX_SYNC_SEL);
  endsequence

  sequence s_mm_irq;
    r_reg.param_mismatch_status && !IRQ_N;
  endsequence

  property p_mm_latch;
    @(posedge CLK) disable iff (SYS_RST)
    s_mm_rise |=> s_mm_irq;
  endproperty
  a_mm_latch: assert property (p_mm_latch) else $error("mismatch not latched");

  property p_mm_clear;
    @(posedge CLK) disable iff (SYS_RST)
    wr && idx == `SLM_IDX_SYNC_SEL && WB_DAT_I[`SLM_B_MM_ST] && !mm_rise |=> !r_reg.param_mismatch_status;
  endproperty
  a_mm_clear: assert property (p_mm_clear) else $error("mismatch status not cleared");

  property p_mm_off;
    @(posedge CLK) disable iff (SYS_RST)
    !r_reg.param_mismatch_irq_on && !wr |=> !r_reg.param_mismatch_status
      && (IRQ_N || |(r_reg.irq_stat & r_reg.irq_mask));
  endproperty
  a_mm_off: assert property (p_mm_off) else $error("disabled mismatch still active");

  property p_reset_vals;
    @(posedge CLK) disable iff (SYS_RST)
    $fell(SYS_RST) |-> r_reg.param_mismatch_irq_on && LANE_ON_BITS == `SLM_RST_LANE_ON
      && r_reg.i_const == 16'h0000 && r_reg.q_const == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");

  property p_dc_out;
    @(posedge CLK) disable iff (SYS_RST)
    r_reg.dig_test[`SLM_B_DC_TEST] |=> I_OUT == $past(r_reg.i_const) && Q_OUT == $past(r_reg.q_const);
  endproperty
  a_dc_out: assert property (p_dc_out) else $error("test constants not on outputs");

  property p_disp_irq;
    @(posedge CLK) disable iff (SYS_RST)
    r_reg.irq_mask[`SLM_B_DISP] && any_disp && !(wr && idx == `SLM_IDX_IRQ_MASK) |=> !IRQ_N;
  endproperty
  a_disp_irq: assert property (p_disp_irq) else $error("disparity limit gave no interrupt");

endmodule : slm_top

// ### verif/slm_tx_model.sv
`timescale 1ns/1ns
module slm_tx_model
  import slm_pkg::*;
#(
  parameter int           NUM_LANES = 8,
  parameter logic [111:0] CFG       = 112'h0
) (
  // clock
  input  wire logic                   clk,
  // error events
  output logic      [NUM_LANES-1:0]   disp,
  output logic      [NUM_LANES-1:0]   nit,
  output logic      [NUM_LANES-1:0]   ucc,
  // alignment sequence
  output logic      [NUM_LANES-1:0]   ilas_begin,
  output logic      [NUM_LANES-1:0]   ilas_valid,
  output logic      [8*NUM_LANES-1:0] ilas_data,
  // sent link parameters
  output logic      [111:0]           params
);
  initial begin
    disp       = '0;
    nit        = '0;
    ucc        = '0;
    ilas_begin = '0;
    ilas_valid = '0;
    ilas_data  = '0;
    params     = CFG;
  end

  // ----------------------------------------
  // one error event per lane per cycle
  // ----------------------------------------
  task automatic errs(input int cls, input logic [NUM_LANES-1:0] lanes, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      if (cls == 0) disp <= lanes;
      else if (cls == 1) nit <= lanes;
      else ucc <= lanes;
      @(posedge clk);
    end
    if (cls == 0) disp <= '0;
    else if (cls == 1) nit <= '0;
    else ucc <= '0;
  endtask : errs

  // ----------------------------------------
  // three alignment bytes on lane 0
  // ----------------------------------------
  task automatic ilas(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      ilas_valid[0]     <= 1'b1;
      ilas_begin[0]     <= (i == 0);
      ilas_data[7:0]    <= b[i];
      @(posedge clk);
    end
    ilas_valid[0]  <= 1'b0;
    ilas_begin[0]  <= 1'b0;
    ilas_data[7:0] <= ~b2;
  endtask : ilas

  task automatic mismatch(input logic on);
    params <= on ? ~CFG : CFG;
  endtask : mismatch
endmodule : slm_tx_model

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import slm_pkg::*;
  localparam logic [111:0] CFG = 112'h0123_4567_89AB_CDEF_0011_2233_4455;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [12:0] adr = 13'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  wsel = 4'hF;
  logic [15:0] i_in = 16'h1234;
  logic [15:0] q_in = 16'h5678;
  logic [111:0] lcl = CFG;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  disp, nit, ucc, ibeg, ival, lanes_on;
  logic [63:0] idat;
  logic [111:0] rxp;
  logic [15:0] i_out, q_out;
  logic        resync_n, irq_n, rfail;
  int          fails = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  slm_tx_model #(.CFG(CFG)) u_tx (.clk(clk), .disp(disp), .nit(nit), .ucc(ucc),
    .ilas_begin(ibeg), .ilas_valid(ival), .ilas_data(idat), .params(rxp));

  slm_top u_dut (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DISP_ERR(disp), .NIT_ERR(nit), .UCC_ERR(ucc), .ILAS_BEGIN(ibeg), .ILAS_VALID(ival),
    .ILAS_DATA(idat), .RX_LANE0_PARAMS(rxp), .LOCAL_PARAMS(lcl), .I_IN(i_in), .Q_IN(q_in),
    .I_OUT(i_out), .Q_OUT(q_out), .RESYNC_REQUEST_OUT_N(resync_n), .IRQ_N(irq_n),
    .LANE_ON_BITS(lanes_on), .ILAS_RAMP_FAIL(rfail));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    fails++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask : tmo

  task automatic wb(input logic w, input logic [10:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= wsel;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [10:0] idx [12] = '{11'h47B, 11'h47C, 11'h47D, 11'h47E, 11'h520, 11'h521, 11'h522,
                              11'h523, 11'h524, 11'h480, 11'h481, 11'h100};
    logic [7:0]  exp [12] = '{8'h08, 8'hFF, 8'h0F, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00};
    logic [7:0]  q;
    chk(lanes_on, 8'h0F);
    chk({irq_n, resync_n}, 2'h3);
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, idx[i], 8'h00, q);
      chk(q, exp[i]);
    end
    wsel = 4'hE;
    wb(1'b1, 11'h47D, 8'h33, q);
    chk(lanes_on, 8'h0F);
    wsel = 4'hF;
    wb(1'b1, 11'h47D, 8'h33, q);
    chk(lanes_on, 8'h33);
    wb(1'b1, 11'h47D, 8'h0F, q);
    chk(lanes_on, 8'h0F);
  endtask : t_reset

  task automatic t_resync();
    logic [7:0] q;
    int         n;
    wb(1'b1, 11'h481, 8'h80, q);
    wb(1'b1, 11'h47C, 8'h03, q);
    wb(1'b1, 11'h47B, 8'hE8, q);
    for (int k = 0; k < 3; k++) u_tx.errs(k, 8'h01, 2);
    u_tx.errs(0, 8'h20, 5);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      if (resync_n === 1'b0) n++;
    end
    chk(16'(n), 16'h0);
    for (int k = 0; k < 3; k++) begin
      u_tx.errs(k, 8'h01, (k == 0) ? 1 : 3);
      n = 0;
      while (resync_n !== 1'b0 && n < 20) begin
        @(posedge clk);
        n++;
      end
      if (n >= 20) tmo();
      n = 0;
      while (resync_n === 1'b0 && n < 10) begin
        n++;
        @(posedge clk);
      end
      chk(16'(n), 16'h4);
      wb(1'b0, 11'h480, 8'h00, q);
      chk(q, 8'h80 >> k);
      chk(irq_n, k != 0);
      wb(1'b1, 11'h480, 8'hFF, q);
    end
  endtask : t_resync

  task automatic t_mismatch();
    logic [7:0] q;
    u_tx.mismatch(1'b1);
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b0);
    wb(1'b0, 11'h47B, 8'h00, q);
    chk(q, 8'hF8);
    wb(1'b1, 11'h47B, 8'hF8, q);
    wb(1'b0, 11'h47B, 8'h00, q);
    chk({irq_n, q}, 9'h1E8);
    wb(1'b1, 11'h47B, 8'hE0, q);
    u_tx.mismatch(1'b0);
    @(posedge clk);
    u_tx.mismatch(1'b1);
    repeat (3) @(posedge clk);
    wb(1'b0, 11'h47B, 8'h00, q);
    chk({irq_n, q}, 9'h1E0);
    wb(1'b1, 11'h47B, 8'hE8, q);
    lcl <= ~CFG;
    repeat (2) @(posedge clk);
    chk(irq_n, 1'b1);
    lcl <= CFG;
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b0);
    u_tx.mismatch(1'b0);
    wb(1'b1, 11'h47B, 8'hF8, q);
    chk(irq_n, 1'b1);
  endtask : t_mismatch

  task automatic t_ramp();
    logic [7:0] q;
    wb(1'b1, 11'h47E, 8'h01, q);
    u_tx.ilas(8'h00, 8'h01, 8'h03);
    repeat (3) @(posedge clk);
    chk(rfail, 1'b1);
    u_tx.ilas(8'h00, 8'h01, 8'h02);
    repeat (3) @(posedge clk);
    chk(rfail, 1'b0);
    wb(1'b1, 11'h47E, 8'h00, q);
    u_tx.ilas(8'h05, 8'h06, 8'h07);
    repeat (3) @(posedge clk);
    chk(rfail, 1'b0);
  endtask : t_ramp

  task automatic t_const();
    logic [7:0] q;
    wb(1'b1, 11'h521, 8'hCD, q);
    wb(1'b1, 11'h522, 8'hAB, q);
    wb(1'b1, 11'h523, 8'h34, q);
    wb(1'b1, 11'h524, 8'h12, q);
    wb(1'b1, 11'h520, 8'h1E, q);
    i_in <= 16'h0F0F;
    q_in <= 16'hF0F0;
    repeat (2) @(posedge clk);
    chk(i_out, 16'hABCD);
    chk(q_out, 16'h1234);
    wb(1'b1, 11'h520, 8'h1C, q);
    repeat (2) @(posedge clk);
    chk(i_out, 16'h0F0F);
    chk(q_out, 16'hF0F0);
  endtask : t_const

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_resync();
    t_mismatch();
    t_ramp();
    t_const();
    end_sim();
  end
endmodule : testbench
